// ---- src/ups_cfg.svh ----
`ifndef UPS_CFG_SVH
`define UPS_CFG_SVH

// ****************************************************
// Clock and timing
// ****************************************************
`define UPS_CLK_PERIOD_NS 5
`define UPS_PIN_RESET_NS 2000
`define UPS_BUS_RESET_NS 2500
`define UPS_SUSPEND_NS 3000000

// ****************************************************
// Register byte offsets
// ****************************************************
`define UPS_OFS_USB_CTRL 8'h00
`define UPS_OFS_SYNTH_CTRL 8'h04
`define UPS_OFS_CLOCK_CTRL 8'h08
`define UPS_OFS_IRQ_STATUS 8'h0c
`define UPS_OFS_IRQ_CLEAR 8'h10
`define UPS_OFS_IRQ_ENABLE 8'h14
`define UPS_OFS_FUNC_ADDR 8'h18

// ****************************************************
// Field positions
// ****************************************************
`define UPS_BIT_CONV_LOW 3
`define UPS_BIT_CONV_EN 4
`define UPS_BIT_USB_CLK_EN 5
`define UPS_BIT_FUNC_EN 7
`define UPS_BIT_SYNTH_EN 0
`define UPS_BIT_SYNTH_LOCK 7
`define UPS_BIT_BUS_RESET 5
`define UPS_BIT_RESUME 6
`define UPS_BIT_SUSPEND 7

// ****************************************************
// Reset values
// ****************************************************
`define UPS_RST_USB_CTRL 8'h00
`define UPS_RST_SYNTH_CFG 6'h00
`define UPS_RST_CLOCK_CTRL 8'h00
`define UPS_RST_IRQ_STATUS 8'h00
`define UPS_RST_IRQ_ENABLE 8'h00
`define UPS_RST_FUNC_ADDR 7'h00

`endif

// ---- src/ups_pkg.sv ----
package ups_pkg;

    typedef logic [7:0] ups_byte_t;
    typedef logic [31:0] ups_word_t;

    typedef enum logic {
        UPS_ACTIVE = 1'b0,
        UPS_SUSPENDED = 1'b1
    } ups_fcu_state_t;

endpackage

// ---- src/ups_top.sv ----
// Local design decisions: the placing of the registers and the APB slave port.
`include "ups_cfg.svh"

module ups_top #(
    parameter int SUSPEND_CYCLES =
        `UPS_SUSPEND_NS / `UPS_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // Device reset sources
    input wire logic RESET_PIN_N,
    input wire logic UNDEF_OPCODE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire ups_pkg::ups_word_t PWDATA,
    output ups_pkg::ups_word_t PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // USB data lines
    input wire logic DP_IN,
    input wire logic DM_IN,
    // Synthesizer, converter, USB clock, controller enable and clock control
    input wire logic SYNTH_LOCKED,
    output logic SYNTH_EN,
    output logic [5:0] SYNTH_CFG,
    output logic CONV_EN,
    output logic CONV_LOW_CURRENT,
    output logic USB_CLK_EN,
    output logic FUNC_EN,
    output ups_pkg::ups_byte_t CLOCK_CTRL,
    // Interrupt
    output logic IRQ
);
    import ups_pkg::*;

    // ****************************************************
    // Timing counts
    // ****************************************************
    localparam int PIN_CYC_I =
        (`UPS_PIN_RESET_NS + `UPS_CLK_PERIOD_NS - 1)
        / `UPS_CLK_PERIOD_NS;
    localparam int BUS_CYC_I =
        (`UPS_BUS_RESET_NS + `UPS_CLK_PERIOD_NS - 1)
        / `UPS_CLK_PERIOD_NS;
    localparam logic [9:0] PIN_CYC = 10'(PIN_CYC_I);
    localparam logic [9:0] BUS_CYC = 10'(BUS_CYC_I);
    localparam logic [19:0] SUSP_CYC = 20'(SUSPEND_CYCLES);

    // ****************************************************
    // Declarations
    // ****************************************************
    logic [9:0] pin_cnt_reg;
    logic hw_rst_reg;
    logic [9:0] se0_cnt_reg;
    logic [19:0] idle_cnt_reg;
    logic bus_rst;
    logic suspend_evt;
    logic resume_evt;
    ups_fcu_state_t fcu_state_reg;
    ups_byte_t usb_ctrl_reg;
    logic [5:0] synth_cfg_reg;
    logic synth_en_reg;
    logic lock_reg;
    ups_byte_t clock_ctrl_reg;
    ups_byte_t irq_status_reg;
    ups_byte_t irq_status_next;
    ups_byte_t irq_enable_reg;
    logic [6:0] func_addr_reg;
    logic pready_reg;
    ups_word_t prdata_reg;
    ups_word_t prdata_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic irq_reg;
    logic access;
    logic wr_en;
    logic se0;
    logic idle_j;
    logic line_on;

    // ****************************************************
    // Hardware reset
    // ****************************************************
    // The pin must stay low strictly longer than the limit, so the
    // reset starts one cycle after the count reaches it.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pin_cnt_reg <= 10'h000;
        end else if (RESET_PIN_N) begin
            pin_cnt_reg <= 10'h000;
        end else if (pin_cnt_reg != PIN_CYC) begin
            pin_cnt_reg <= pin_cnt_reg + 10'h001;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            hw_rst_reg <= 1'b1;
        end else begin
            hw_rst_reg <= UNDEF_OPCODE
                | (~RESET_PIN_N & (pin_cnt_reg == PIN_CYC));
        end
    end

    // ****************************************************
    // Line monitor
    // ****************************************************
    assign se0 = ~DP_IN & ~DM_IN;
    assign idle_j = DP_IN & ~DM_IN;
    // Without the USB clock and controller enable the line is not watched
    // for bus reset or suspend, which keeps an unpowered driver from faking resets.
    assign line_on = usb_ctrl_reg[`UPS_BIT_USB_CLK_EN]
        & usb_ctrl_reg[`UPS_BIT_FUNC_EN];

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            se0_cnt_reg <= 10'h000;
        end else if (hw_rst_reg || !se0 || !line_on) begin
            se0_cnt_reg <= 10'h000;
        end else if (se0_cnt_reg != BUS_CYC) begin
            se0_cnt_reg <= se0_cnt_reg + 10'h001;
        end
    end

    assign bus_rst = line_on & se0
        & (se0_cnt_reg == BUS_CYC - 10'h001);

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            idle_cnt_reg <= 20'h00000;
        end else if (hw_rst_reg || bus_rst) begin
            idle_cnt_reg <= 20'h00000;
        end else if (!idle_j || !line_on
                     || fcu_state_reg == UPS_SUSPENDED) begin
            idle_cnt_reg <= 20'h00000;
        end else if (idle_cnt_reg != SUSP_CYC) begin
            idle_cnt_reg <= idle_cnt_reg + 20'h00001;
        end
    end

    assign suspend_evt = line_on & idle_j
        & (fcu_state_reg == UPS_ACTIVE)
        & (idle_cnt_reg == SUSP_CYC - 20'h00001);
    // Resume is watched even with the USB clock stopped, since
    // firmware turns it off before entering stop.
    assign resume_evt = (fcu_state_reg == UPS_SUSPENDED)
        & ~idle_j;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            fcu_state_reg <= UPS_ACTIVE;
        end else if (hw_rst_reg || bus_rst) begin
            fcu_state_reg <= UPS_ACTIVE;
        end else begin
            unique case (fcu_state_reg)
                UPS_ACTIVE: begin
                    if (suspend_evt) begin
                        fcu_state_reg <= UPS_SUSPENDED;
                    end
                end
                UPS_SUSPENDED: begin
                    if (resume_evt) begin
                        fcu_state_reg <= UPS_ACTIVE;
                    end
                end
            endcase
        end
    end

    // ****************************************************
    // APB access
    // ****************************************************
    assign access = PSEL & PENABLE;
    assign wr_en = access & pready_reg & PWRITE;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= access & ~pready_reg;
        end
    end

    always_comb begin
        prdata_next = 32'h00000000;
        pslverr_next = 1'b0;
        unique case (PADDR)
            `UPS_OFS_USB_CTRL: prdata_next[7:0] = usb_ctrl_reg;
            `UPS_OFS_SYNTH_CTRL:
                prdata_next[7:0] = {lock_reg, synth_cfg_reg,
                                    synth_en_reg};
            `UPS_OFS_CLOCK_CTRL: prdata_next[7:0] = clock_ctrl_reg;
            `UPS_OFS_IRQ_STATUS: prdata_next[7:0] = irq_status_reg;
            `UPS_OFS_IRQ_CLEAR: prdata_next = 32'h00000000;
            `UPS_OFS_IRQ_ENABLE: prdata_next[7:0] = irq_enable_reg;
            `UPS_OFS_FUNC_ADDR: prdata_next[6:0] = func_addr_reg;
            default: pslverr_next = 1'b1;
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (access && !pready_reg) begin
            prdata_reg <= PWRITE ? 32'h00000000 : prdata_next;
            pslverr_reg <= pslverr_next;
        end else begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
    end

    // ****************************************************
    // Power and clock control
    // ****************************************************
    // These survive a bus reset so the supply and clock stay up.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            usb_ctrl_reg <= `UPS_RST_USB_CTRL;
        end else if (hw_rst_reg) begin
            usb_ctrl_reg <= `UPS_RST_USB_CTRL;
        end else if (wr_en && PADDR == `UPS_OFS_USB_CTRL) begin
            usb_ctrl_reg <= PWDATA[7:0];
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            synth_cfg_reg <= `UPS_RST_SYNTH_CFG;
            synth_en_reg <= 1'b0;
        end else if (hw_rst_reg) begin
            synth_cfg_reg <= `UPS_RST_SYNTH_CFG;
            synth_en_reg <= 1'b0;
        end else if (wr_en && PADDR == `UPS_OFS_SYNTH_CTRL) begin
            synth_cfg_reg <= PWDATA[6:1];
            synth_en_reg <= PWDATA[`UPS_BIT_SYNTH_EN];
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            lock_reg <= 1'b0;
        end else begin
            lock_reg <= SYNTH_LOCKED & synth_en_reg
                & ~hw_rst_reg;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            clock_ctrl_reg <= `UPS_RST_CLOCK_CTRL;
        end else if (hw_rst_reg) begin
            clock_ctrl_reg <= `UPS_RST_CLOCK_CTRL;
        end else if (wr_en && PADDR == `UPS_OFS_CLOCK_CTRL) begin
            clock_ctrl_reg <= PWDATA[7:0];
        end
    end

    // ****************************************************
    // Controller registers
    // ****************************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            func_addr_reg <= `UPS_RST_FUNC_ADDR;
        end else if (hw_rst_reg || bus_rst) begin
            func_addr_reg <= `UPS_RST_FUNC_ADDR;
        end else if (wr_en && PADDR == `UPS_OFS_FUNC_ADDR) begin
            func_addr_reg <= PWDATA[6:0];
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            irq_enable_reg <= `UPS_RST_IRQ_ENABLE;
        end else if (hw_rst_reg || bus_rst) begin
            irq_enable_reg <= `UPS_RST_IRQ_ENABLE;
        end else if (wr_en && PADDR == `UPS_OFS_IRQ_ENABLE) begin
            irq_enable_reg <= PWDATA[7:0];
        end
    end

    // An event in the same cycle as a clear keeps its flag set.
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_en && PADDR == `UPS_OFS_IRQ_CLEAR) begin
            irq_status_next = irq_status_reg & ~PWDATA[7:0];
        end
        if (suspend_evt) begin
            irq_status_next[`UPS_BIT_SUSPEND] = 1'b1;
        end
        if (resume_evt) begin
            irq_status_next[`UPS_BIT_RESUME] = 1'b1;
        end
        if (bus_rst) begin
            irq_status_next = `UPS_RST_IRQ_STATUS;
            irq_status_next[`UPS_BIT_BUS_RESET] = 1'b1;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            irq_status_reg <= `UPS_RST_IRQ_STATUS;
        end else if (hw_rst_reg) begin
            irq_status_reg <= `UPS_RST_IRQ_STATUS;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // ****************************************************
    // Interrupt
    // ****************************************************
    // Bus reset always interrupts because the same event has just
    // cleared the enable register.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= ~hw_rst_reg
                & (irq_status_next[`UPS_BIT_BUS_RESET]
                   | (irq_enable_reg[`UPS_BIT_SUSPEND]
                      & (irq_status_next[`UPS_BIT_SUSPEND]
                         | irq_status_next[`UPS_BIT_RESUME]))
                   | |(irq_status_next & irq_enable_reg
                       & 8'h1f));
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign SYNTH_EN = synth_en_reg;
    assign SYNTH_CFG = synth_cfg_reg;
    assign CONV_EN = usb_ctrl_reg[`UPS_BIT_CONV_EN];
    assign CONV_LOW_CURRENT = usb_ctrl_reg[`UPS_BIT_CONV_LOW];
    assign USB_CLK_EN = usb_ctrl_reg[`UPS_BIT_USB_CLK_EN];
    assign FUNC_EN = usb_ctrl_reg[`UPS_BIT_FUNC_EN];
    assign CLOCK_CTRL = clock_ctrl_reg;
    assign IRQ = irq_reg;

endmodule

// ---- verif/ups_assertions.sv ----
module ups_assertions #(
    parameter int SUSPEND_CYCLES = 600000
) (
    // Clock and resets
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic RESET_PIN_N,
    input wire logic UNDEF_OPCODE,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire ups_pkg::ups_word_t PRDATA,
    input wire logic PREADY,
    // Line, power and interrupt
    input wire logic DP_IN,
    input wire logic DM_IN,
    input wire logic SYNTH_LOCKED,
    input wire logic SYNTH_EN,
    input wire logic CONV_EN,
    input wire logic CONV_LOW_CURRENT,
    input wire logic USB_CLK_EN,
    input wire logic FUNC_EN,
    input wire ups_pkg::ups_byte_t CLOCK_CTRL,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    import ups_pkg::*;
    // ****************
    // Helper counters
    // ****************
    logic [9:0] se0_cnt, pin_cnt;
    logic [1:0] lk_cnt, off_cnt;
    logic fa_clr, se0, lon, brst, rd_lock, all_clr;
    logic [12:0] ctl;
    assign se0 = !DP_IN && !DM_IN;
    assign lon = USB_CLK_EN && FUNC_EN;
    assign brst = se0_cnt == 10'h1f3 && se0 && lon && RESET_PIN_N
        && !UNDEF_OPCODE;
    assign rd_lock = PSEL && PENABLE && PREADY && !PWRITE && PADDR == 8'h04;
    assign ctl = {SYNTH_EN, CONV_EN, CONV_LOW_CURRENT, USB_CLK_EN, FUNC_EN,
        CLOCK_CTRL};
    assign all_clr = !(SYNTH_EN || CONV_EN || CONV_LOW_CURRENT ||
        USB_CLK_EN || FUNC_EN || IRQ) && CLOCK_CTRL == 8'h00;
    // Counters saturate so that each boundary is seen once per stretch.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            se0_cnt <= 10'h000;
            pin_cnt <= 10'h000;
            lk_cnt <= 2'h0;
            off_cnt <= 2'h0;
            fa_clr <= 1'b0;
        end else begin
            se0_cnt <= !(se0 && lon) ? 10'h000 : se0_cnt + {9'h0, ~&se0_cnt};
            pin_cnt <= RESET_PIN_N ? 10'h000 : pin_cnt + {9'h0, ~&pin_cnt};
            lk_cnt <= !(SYNTH_EN && SYNTH_LOCKED) ? 2'h0 :
                lk_cnt + {1'b0, ~&lk_cnt};
            off_cnt <= SYNTH_EN ? 2'h0 : off_cnt + {1'b0, ~&off_cnt};
            if (brst) begin
                fa_clr <= 1'b1;
            end else if (PSEL && PENABLE && PREADY && PWRITE &&
                         PADDR == 8'h18) begin
                fa_clr <= 1'b0;
            end
        end
    end
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);
    sequence s_wait;
        !PREADY ##1 PREADY;
    endsequence
    sequence s_busrst;
        brst;
    endsequence
    property p_ready;
        PSEL && !PENABLE |=> s_wait;
    endproperty
    property p_opcode;
        UNDEF_OPCODE |-> ##3 all_clr;
    endproperty
    property p_pin;
        pin_cnt >= 10'h194 |-> all_clr;
    endproperty
    property p_keep;
        s_busrst ##0 !PSEL |=> $stable(ctl) [*2];
    endproperty
    property p_busirq;
        s_busrst |-> ##2 IRQ;
    endproperty
    property p_lock;
        rd_lock && lk_cnt == 2'h3 |-> PRDATA[7];
    endproperty
    property p_nolock;
        rd_lock && off_cnt == 2'h3 |-> !PRDATA[7];
    endproperty
    property p_addr_clr;
        PSEL && PENABLE && PREADY && !PWRITE && PADDR == 8'h18 && fa_clr
            |-> PRDATA == 32'h0;
    endproperty
    a_ready: assert property (p_ready)
        else $error("answer not on second edge");
    a_opcode: assert property (p_opcode)
        else $error("opcode reset missing");
    a_pin: assert property (p_pin)
        else $error("pin reset missing");
    a_keep: assert property (p_keep)
        else $error("control changed by bus reset");
    a_busirq: assert property (p_busirq)
        else $error("no interrupt on bus reset");
    a_lock: assert property (p_lock)
        else $error("lock not shown");
    a_nolock: assert property (p_nolock)
        else $error("lock shown while off");
    a_addr_clr: assert property (p_addr_clr)
        else $error("address kept over bus reset");
endmodule

bind ups_top ups_assertions #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) u_chk (
    .MCLK, .RESET, .RESET_PIN_N, .UNDEF_OPCODE, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PRDATA, .PREADY, .DP_IN, .DM_IN, .SYNTH_LOCKED, .SYNTH_EN,
    .CONV_EN, .CONV_LOW_CURRENT, .USB_CLK_EN, .FUNC_EN, .CLOCK_CTRL, .IRQ
);

// ---- verif/ups_host.sv ----
module ups_host (
    // Clock
    input wire logic clk,
    // Line levels
    output logic dp,
    output logic dm
);
    timeunit 1ns;
    timeprecision 1ps;
    // The hub always drives the pair, so it never floats; idle is J.
    initial begin
        dp = 1'b1;
        dm = 1'b0;
    end
    // Holds one line state for n sampling edges; SE0 held for 500 samples is a bus reset.
    task automatic line(input logic p, input logic m, input int n);
        @(posedge clk);
        dp <= p;
        dm <= m;
        // The next call changes the level one edge later, so the last
        // of the n samples falls on that edge.
        repeat (n - 1) @(posedge clk);
    endtask
endmodule

// ---- verif/usb_power_clock_sequencer_bench.sv ----
module usb_power_clock_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ups_pkg::*;
    // Short idle span keeps suspend tests brief.
    localparam int SUSP = 2000;
    logic mclk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1, undef_opcode = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, synth_locked = 1'b1;
    logic [7:0] paddr = 8'h00;
    ups_word_t pwdata = 32'h0, prdata, d;
    logic pready, pslverr, e, dp, dm, irq;
    logic synth_en, conv_en, conv_low, usb_clk_en, func_en;
    logic [5:0] synth_cfg;
    ups_byte_t clock_ctrl;
    int n_errors = 0, tests_run = 0;
    always #2.5 mclk = ~mclk;
    ups_top #(.SUSPEND_CYCLES(SUSP)) dut (
        .MCLK(mclk), .RESET(rst), .RESET_PIN_N(reset_pin_n),
        .UNDEF_OPCODE(undef_opcode), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DP_IN(dp), .DM_IN(dm),
        .SYNTH_LOCKED(synth_locked), .SYNTH_EN(synth_en),
        .SYNTH_CFG(synth_cfg), .CONV_EN(conv_en),
        .CONV_LOW_CURRENT(conv_low), .USB_CLK_EN(usb_clk_en),
        .FUNC_EN(func_en), .CLOCK_CTRL(clock_ctrl), .IRQ(irq)
    );
    ups_host host (.clk(mclk), .dp(dp), .dm(dm));
    // ****************
    // Shared tasks
    // ****************
    task automatic cmp(input ups_word_t got, input ups_word_t exp,
                       input string m);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input ups_word_t v);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cmp(32'(n < 20), 32'h1, "no answer");
    endtask
    task automatic rdc(input logic [7:0] a, input ups_word_t x, string m);
        apb(1'b0, a, 32'h0);
        cmp(d, x, m);
    endtask
    task automatic settle;
        repeat (2) @(negedge mclk);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            rdc(8'(i * 4), 32'h0, "reset value");
            cmp(32'(e), 32'(i == 7), "slave error");
        end
        apb(1'b1, 8'h0c, 32'hff);
        rdc(8'h0c, 32'h0, "status written");
    endtask
    task automatic t_bringup;
        apb(1'b1, 8'h04, 32'h2a);
        rdc(8'h04, 32'h2a, "lock while off");
        apb(1'b1, 8'h04, 32'h2b);
        rdc(8'h04, 32'hab, "lock");
        synth_locked <= 1'b0;
        repeat (2) @(posedge mclk);
        rdc(8'h04, 32'h2b, "lock lost");
        synth_locked <= 1'b1;
        apb(1'b1, 8'h00, 32'h10);
        settle;
        cmp(32'({conv_en, conv_low}), 32'h2, "converter");
        apb(1'b1, 8'h00, 32'h30);
        repeat (4) @(posedge mclk);
        apb(1'b1, 8'h00, 32'hb0);
        apb(1'b1, 8'h08, 32'h5a);
        settle;
        cmp(32'({synth_cfg, synth_en, usb_clk_en, func_en, clock_ctrl}),
            32'({7'h2b, 2'h3, 8'h5a}), "outputs");
    endtask
    task automatic t_busreset;
        apb(1'b1, 8'h18, 32'h55);
        apb(1'b1, 8'h14, 32'h80);
        host.line(1'b0, 1'b0, 499);
        host.line(1'b1, 1'b0, 4);
        rdc(8'h0c, 32'h0, "short se0");
        host.line(1'b0, 1'b0, 520);
        host.line(1'b1, 1'b0, 1);
        settle;
        cmp(32'(irq), 32'h1, "bus reset irq");
        rdc(8'h0c, 32'h20, "bus reset flag");
        rdc(8'h18, 32'h0, "address cleared");
        rdc(8'h14, 32'h0, "enable cleared");
        rdc(8'h00, 32'hb0, "control kept");
        rdc(8'h04, 32'hab, "synth kept");
        rdc(8'h08, 32'h5a, "clock control kept");
        apb(1'b1, 8'h10, 32'h20);
        settle;
        cmp(32'(irq), 32'h0, "irq cleared");
        apb(1'b1, 8'h18, 32'h55);
        rdc(8'h18, 32'h55, "address restored");
    endtask
    task automatic t_suspend;
        rdc(8'h0c, 32'h0, "early suspend");
        host.line(1'b1, 1'b0, SUSP + 8);
        rdc(8'h0c, 32'h80, "suspend flag");
        cmp(32'(irq), 32'h0, "suspend masked");
        apb(1'b1, 8'h14, 32'h80);
        settle;
        cmp(32'(irq), 32'h1, "suspend irq");
        apb(1'b1, 8'h10, 32'h80);
        apb(1'b1, 8'h00, 32'h98);
        apb(1'b1, 8'h04, 32'h2a);
        settle;
        cmp(32'(irq), 32'h0, "suspend cleared");
        host.line(1'b0, 1'b1, 3);
        host.line(1'b1, 1'b0, 1);
        settle;
        cmp(32'(irq), 32'h1, "resume irq");
        rdc(8'h0c, 32'h40, "resume flag");
        apb(1'b1, 8'h00, 32'h90);
        apb(1'b1, 8'h04, 32'h2b);
        rdc(8'h04, 32'hab, "relock");
        apb(1'b1, 8'h00, 32'hb0);
    endtask
    task automatic t_hwreset;
        reset_pin_n <= 1'b0;
        repeat (399) @(posedge mclk);
        reset_pin_n <= 1'b1;
        settle;
        cmp(32'(conv_en), 32'h1, "short pin pulse");
        @(posedge mclk);
        reset_pin_n <= 1'b0;
        repeat (410) @(posedge mclk);
        settle;
        cmp(32'({synth_en, conv_en, func_en, irq, clock_ctrl}), 32'h0,
            "pin");
        @(posedge mclk);
        reset_pin_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdc(8'h0c, 32'h0, "status after pin");
        apb(1'b1, 8'h00, 32'h10);
        @(posedge mclk);
        undef_opcode <= 1'b1;
        @(posedge mclk);
        undef_opcode <= 1'b0;
        repeat (3) @(negedge mclk);
        cmp(32'(conv_en), 32'h0, "opcode reset");
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        t_regs;
        t_bringup;
        t_busreset;
        t_suspend;
        t_hwreset;
        close_out;
    end
    // Whole run is under 6000 cycles, so this only cuts a hang.
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        close_out;
    end
endmodule
